//--- src/fp_exc_defs.vh
/*
 * constants for the floating-point exception unit: control-register
 * flag positions, APB offsets, operation classes and operand classes.
 * assumes nothing; definitions only.
 */
`ifndef FP_EXC_DEFS_VH
`define FP_EXC_DEFS_VH

// apb register byte offsets
`define FPX_OFF_FLAGS 12'h000
`define FPX_OFF_LAST 12'h004
`define FPX_OFF_COUNT 12'h008

// flag bit positions in the control register word
`define FPX_INV 0
`define FPX_DZE 1
`define FPX_OVF 2
`define FPX_UNF 3
`define FPX_INE 4
`define FPX_IOV 5
`define FPX_NFLAGS 6
`define FPX_FLAGS_RST 6'h00

// operation classes presented with each result
`define FPX_OP_ARITH 3'h0
`define FPX_OP_DIV 3'h1
`define FPX_OP_NOEXC 3'h2
`define FPX_OP_CVT_FQ 3'h3
`define FPX_OP_CVT_QL 3'h4
`define FPX_OP_CMP 3'h5

// operand classes
`define FPX_CL_ZERO 3'h0
`define FPX_CL_FINITE 3'h1
`define FPX_CL_DENORM 3'h2
`define FPX_CL_INF 3'h3
`define FPX_CL_NAN 3'h4
`define FPX_CL_RESOP 3'h5
`define FPX_CL_DIRTYZ 3'h6

`endif

//--- src/fp_operand_check.v
/*
 * classifies one operand as valid, zero or non-finite for both the
 * ieee and the legacy format.
 * assumes the datapath supplies a pre-decoded operand class.
 */
`timescale 1ns/1ns
`include "fp_exc_defs.vh"

module fp_operand_check (
    input wire [2:0] class_i,
    input wire ieee_i,
    output wire nonfinite_o,
    output wire zero_o
);
    // ieee: nan, infinity, denormal; legacy: reserved operand, dirty zero
    assign nonfinite_o = ieee_i ?
        ((class_i == `FPX_CL_NAN) || (class_i == `FPX_CL_INF) ||
         (class_i == `FPX_CL_DENORM)) :
        ((class_i == `FPX_CL_RESOP) || (class_i == `FPX_CL_DIRTYZ));
    // true zero of either sign
    assign zero_o = (class_i == `FPX_CL_ZERO);
endmodule // fp_operand_check

//--- src/fp_exception_detect.v
/*
 * floating-point exception detection: classifies each completing
 * operation, fixes the destination value, records sticky flags in the
 * control register (apb) and signals traps to the issue unit.
 * assumes the datapath gives operand classes, the rounded result,
 * range indications and the instruction's trap qualifiers in one cycle.
 */
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "fp_exc_defs.vh"

// Summary of operation
// - invalid trap always on, destination unpredictable
// - non-finite operand raises invalid unless exempt
// - ieee zero over zero is invalid only
// - invalid sets flag and traps issue unit
// - divide-by-zero always traps; legacy zero denominator
// - ieee: valid nonzero numerator, zero denominator
// - divide-by-zero sets flag and traps
// - overflow on float destinations beyond largest
// - overflow sets flag and traps
// - underflow forces all-zero 64-bit result
// - underflow below smallest; never produce denormals
// - underflow flag always; trap only if enabled
// - inexact keeps rounded value, flags difference
// - inexact flag always; trap only if enabled
// - inexact enabled: overflows also raise inexact
// - quad-to-long overflow sets inexact, never traps it
// - integer overflow keeps low-order result bits
// - float-to-quad overflow outside signed 64-bit
// - quad-to-long overflow outside signed 32-bit
// - integer overflow flag; trap only if enabled
// - software-completion qualifier forwarded, never recorded
// - input exceptions override output exceptions
module fp_exception_detect #(
    parameter DATA_W = 64
) (
    input wire clock_i,
    input wire reset_i,
    // operation presented by the datapath
    input wire op_valid_i,
    input wire [2:0] op_class_i,
    input wire ieee_i,
    input wire [2:0] src_a_class_i,
    input wire [2:0] src_b_class_i,
    input wire [DATA_W-1:0] rounded_result_i,
    input wire [DATA_W-1:0] true_result_low_i,
    input wire result_too_large_i,
    input wire result_too_small_i,
    input wire result_inexact_i,
    input wire int_out_of_range_i,
    input wire underflow_trap_en_i,
    input wire inexact_trap_en_i,
    input wire int_overflow_trap_en_i,
    input wire software_completion_qualifier_i,
    // destination write to the register file
    output reg dest_valid_o,
    output reg [DATA_W-1:0] dest_data_o,
    output reg dest_unpredictable_o,
    // trap report to the issue unit
    output reg trap_valid_o,
    output reg [`FPX_NFLAGS-1:0] trap_kind_o,
    output reg software_completion_qualifier_o,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr
);
    // operand checks
    wire a_nonfinite; // first operand non-finite
    wire a_zero; // first operand zero
    wire b_nonfinite; // second operand non-finite
    wire b_zero; // second operand zero

    fp_operand_check u_check_a (
        .class_i(src_a_class_i),
        .ieee_i(ieee_i),
        .nonfinite_o(a_nonfinite),
        .zero_o(a_zero)
    );

    fp_operand_check u_check_b (
        .class_i(src_b_class_i),
        .ieee_i(ieee_i),
        .nonfinite_o(b_nonfinite),
        .zero_o(b_zero)
    );

    // decoded operation kinds
    wire is_div = (op_class_i == `FPX_OP_DIV);
    wire is_noexc = (op_class_i == `FPX_OP_NOEXC);
    wire is_cvt_fq = (op_class_i == `FPX_OP_CVT_FQ);
    wire is_cvt_ql = (op_class_i == `FPX_OP_CVT_QL);
    // conversions and compares have no floating destination
    wire float_dest = !(is_cvt_fq || is_cvt_ql || (op_class_i == `FPX_OP_CMP));

    // raw condition detection
    reg inv_raw; // invalid operation
    reg dze_raw; // divide by zero
    reg ovf_raw; // floating overflow
    reg unf_raw; // floating underflow
    reg ine_raw; // inexact
    reg iov_raw; // integer overflow
    reg input_exc; // an operand-side exception exists

    // classify the completing operation
    always @* begin
        inv_raw = 1'b0;
        dze_raw = 1'b0;
        ovf_raw = 1'b0;
        unf_raw = 1'b0;
        ine_raw = 1'b0;
        iov_raw = 1'b0;
        if (op_valid_i && !is_noexc) begin
            // non-finite operand on an excepting instruction
            inv_raw = a_nonfinite || (b_nonfinite && !is_cvt_fq && !is_cvt_ql);
            // ieee zero divided by zero
            if (is_div && ieee_i && a_zero && b_zero) begin
                inv_raw = 1'b1;
            end
            // divide by zero with valid numerator
            if (is_div && !b_nonfinite && b_zero && !a_nonfinite) begin
                dze_raw = ieee_i ? !a_zero : 1'b1;
            end
            // overflow only for floating destinations
            ovf_raw = float_dest && result_too_large_i;
            // too small rounds to underflow, no denormals
            unf_raw = float_dest && result_too_small_i;
            // integer overflow in the two conversions
            iov_raw = (is_cvt_fq || is_cvt_ql) && int_out_of_range_i;
            // rounded value differs from exact one
            ine_raw = result_inexact_i;
            // range exceptions imply inexact when trap enabled
            if (inexact_trap_en_i && (ovf_raw || unf_raw || iov_raw)) begin
                ine_raw = 1'b1;
            end
            // quad-to-long overflow always marks inexact
            if (is_cvt_ql && iov_raw) begin
                ine_raw = 1'b1;
            end
        end
        input_exc = inv_raw || dze_raw;
    end

    // prioritised exception set: inputs hide outputs
    wire [`FPX_NFLAGS-1:0] exc_set;
    assign exc_set[`FPX_INV] = inv_raw;
    assign exc_set[`FPX_DZE] = dze_raw;
    assign exc_set[`FPX_OVF] = ovf_raw && !input_exc;
    assign exc_set[`FPX_UNF] = unf_raw && !input_exc;
    assign exc_set[`FPX_INE] = ine_raw && !input_exc;
    assign exc_set[`FPX_IOV] = iov_raw && !input_exc;

    // trap gating by qualifier enables
    wire [`FPX_NFLAGS-1:0] trap_set;
    assign trap_set[`FPX_INV] = exc_set[`FPX_INV];
    assign trap_set[`FPX_DZE] = exc_set[`FPX_DZE];
    assign trap_set[`FPX_OVF] = exc_set[`FPX_OVF];
    assign trap_set[`FPX_UNF] = exc_set[`FPX_UNF] && underflow_trap_en_i;
    assign trap_set[`FPX_INE] = exc_set[`FPX_INE] && inexact_trap_en_i
        && !is_cvt_ql;
    assign trap_set[`FPX_IOV] = exc_set[`FPX_IOV] && int_overflow_trap_en_i;

    // destination value selection
    reg [DATA_W-1:0] dest_nxt;
    always @* begin
        if (exc_set[`FPX_UNF]) begin
            dest_nxt = {DATA_W{1'b0}};
        end else if (exc_set[`FPX_IOV]) begin
            dest_nxt = true_result_low_i;
        end else begin
            dest_nxt = rounded_result_i;
        end
    end

    // control register state
    reg [`FPX_NFLAGS-1:0] flags_r; // sticky exception flags
    reg [`FPX_NFLAGS-1:0] last_exc_r; // exceptions of last operation
    reg [15:0] trap_count_r; // traps signalled so far

    // apb decode
    wire apb_wr = psel && penable && pwrite;
    wire wr_flags = apb_wr && (paddr == `FPX_OFF_FLAGS);
    wire addr_ok = (paddr == `FPX_OFF_FLAGS) || (paddr == `FPX_OFF_LAST) ||
        (paddr == `FPX_OFF_COUNT);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // destination and trap outputs, one cycle after the operation
    always @(posedge clock_i) begin
        if (reset_i) begin
            dest_valid_o <= 1'b0;
            dest_data_o <= {DATA_W{1'b0}};
            dest_unpredictable_o <= 1'b0;
            trap_valid_o <= 1'b0;
            trap_kind_o <= `FPX_FLAGS_RST;
            software_completion_qualifier_o <= 1'b0;
        end else begin
            dest_valid_o <= op_valid_i;
            dest_data_o <= op_valid_i ? dest_nxt : dest_data_o;
            // invalid, divide-by-zero, overflow leave destination undefined
            dest_unpredictable_o <= op_valid_i && (exc_set[`FPX_INV] ||
                exc_set[`FPX_DZE] || exc_set[`FPX_OVF]);
            trap_valid_o <= op_valid_i && (trap_set != {`FPX_NFLAGS{1'b0}});
            trap_kind_o <= op_valid_i ? trap_set : `FPX_FLAGS_RST;
            // qualifier goes to issue unit every operation
            software_completion_qualifier_o <= op_valid_i &&
                software_completion_qualifier_i;
        end
    end

    // sticky flags: a hardware set wins over a software clear
    always @(posedge clock_i) begin
        if (reset_i) begin
            flags_r <= `FPX_FLAGS_RST;
            last_exc_r <= `FPX_FLAGS_RST;
            trap_count_r <= 16'h0000;
        end else begin
            // write-one-to-clear, then merge new events
            flags_r <= (wr_flags ? (flags_r & ~pwdata[`FPX_NFLAGS-1:0]) : flags_r)
                | exc_set;
            if (op_valid_i) begin
                last_exc_r <= exc_set;
            end
            if (op_valid_i && (trap_set != {`FPX_NFLAGS{1'b0}})) begin
                trap_count_r <= trap_count_r + 16'h0001;
            end
        end
    end

    // read data mux, registered at the end of the setup cycle
    always @(posedge clock_i) begin
        if (reset_i) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `FPX_OFF_FLAGS: begin
                    prdata <= {26'h0000000, flags_r};
                end
                `FPX_OFF_LAST: begin
                    prdata <= {26'h0000000, last_exc_r};
                end
                `FPX_OFF_COUNT: begin
                    prdata <= {16'h0000, trap_count_r};
                end
                default: begin
                    prdata <= 32'h00000000;
                end
            endcase
        end
    end
endmodule // fp_exception_detect

//--- bench/fp_exc_chk.sv
/* port checker for the exception unit.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
module fp_exc_chk #(parameter DATA_W = 64) (
    input logic clock_i,
    input logic reset_i,
    input logic op_valid_i,
    input logic [2:0] op_class_i,
    input logic ieee_i,
    input logic [2:0] src_a_class_i,
    input logic [2:0] src_b_class_i,
    input logic [DATA_W-1:0] true_result_low_i,
    input logic result_too_large_i,
    input logic result_too_small_i,
    input logic int_out_of_range_i,
    input logic inexact_trap_en_i,
    input logic software_completion_qualifier_i,
    input logic dest_valid_o,
    input logic [DATA_W-1:0] dest_data_o,
    input logic trap_valid_o,
    input logic [5:0] trap_kind_o,
    input logic software_completion_qualifier_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // plain arithmetic op on two finite operands
    wire ar = op_valid_i && op_class_i == 3'h0 && src_a_class_i == 3'h1 && src_b_class_i == 3'h1;
    // division on a finite numerator and zero denominator
    wire dz = op_valid_i && op_class_i == 3'h1 && src_a_class_i == 3'h1 && src_b_class_i == 3'h0;
    a_swc_forward: assert property (op_valid_i |=> dest_valid_o &&
        software_completion_qualifier_o == $past(software_completion_qualifier_i))
        else $error("qualifier not forwarded");
    a_inv_nan: assert property (op_valid_i && ieee_i && op_class_i != 3'h2 &&
        src_a_class_i == 3'h4 |=> trap_valid_o && trap_kind_o[0]) else $error("nan not invalid");
    a_copy_exempt: assert property (op_valid_i && op_class_i == 3'h2 |=> !trap_valid_o)
        else $error("sign copy trapped");
    a_zero_zero: assert property (op_valid_i && ieee_i && op_class_i == 3'h1 &&
        src_a_class_i == 3'h0 && src_b_class_i == 3'h0 |=> trap_kind_o[1:0] == 2'h1)
        else $error("zero over zero");
    a_dze_only: assert property (dz |=> trap_valid_o && trap_kind_o == 6'h02)
        else $error("divide by zero kind");
    a_ovf_trap: assert property (ar && result_too_large_i |=> trap_valid_o && trap_kind_o[2])
        else $error("overflow not trapped");
    a_ovf_ine: assert property (ar && result_too_large_i && inexact_trap_en_i |=>
        trap_kind_o[4]) else $error("overflow lacks inexact");
    a_unf_zero: assert property (ar && result_too_small_i |=> dest_data_o == '0)
        else $error("underflow result not zero");
    a_iov_low: assert property (op_valid_i && op_class_i == 3'h3 && int_out_of_range_i &&
        src_a_class_i == 3'h1
        |=> dest_data_o == $past(true_result_low_i)) else $error("integer overflow data");
    a_ql_no_ine: assert property (op_valid_i && op_class_i == 3'h4 |=>
        !(trap_valid_o && trap_kind_o[4])) else $error("inexact trap on narrowing");
    // main scenarios reached
    c_dze: cover property (dz ##1 trap_valid_o);
    c_unf: cover property (ar && result_too_small_i);
    c_swc: cover property (trap_valid_o && software_completion_qualifier_o);
endmodule // fp_exc_chk
bind fp_exception_detect fp_exc_chk #(.DATA_W(DATA_W)) u_chk (.*);

//--- bench/issue_unit_model.sv
/* issue-unit stand-in: takes trap reports, keeps the completion summary bit.
   assumes the exception unit's clock and reset. */
`timescale 1ns/1ns
module issue_unit_model (
    input logic clock_i,
    input logic reset_i,
    input logic trap_valid_i,
    input logic swc_i,
    output logic swc_summary_o
);
    // summary bit is set when a trap meets the completion qualifier
    always @(posedge clock_i) begin
        if (reset_i) begin
            swc_summary_o <= 1'b0;
        end else if (trap_valid_i && swc_i) begin
            swc_summary_o <= 1'b1;
        end
    end
endmodule // issue_unit_model

//--- bench/testbench.sv
/* self-checking bench for the exception unit: ops, then apb reads.
   assumes a one-cycle op answer and a zero-wait apb slave. */
`timescale 1ns/1ns
module testbench;
    localparam logic [63:0] RR = 64'hc000_0000_0000_1234; // rounded value
    localparam logic [63:0] TL = 64'h0000_0001_8000_0000; // low integer bits
    logic clock_i, reset_i, op_valid_i, ieee_i, swc_i, psel, penable, pwrite;
    logic dest_valid_o, trap_valid_o, swc_o, pready, pslverr, se, summ, unp;
    logic [2:0] op_class_i, src_a_class_i, src_b_class_i, en; // en: iov, ine, unf
    logic [3:0] rng; // too large, too small, inexact, out of range
    logic [63:0] dest_data_o;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] trap_kind_o, k, acc;
    int err_total, check_count, cyc, ntrap;
    fp_exception_detect DUT (.clock_i(clock_i), .reset_i(reset_i), .op_valid_i(op_valid_i),
        .op_class_i(op_class_i), .ieee_i(ieee_i), .src_a_class_i(src_a_class_i),
        .src_b_class_i(src_b_class_i), .rounded_result_i(RR), .true_result_low_i(TL),
        .result_too_large_i(rng[3]), .result_too_small_i(rng[2]), .result_inexact_i(rng[1]),
        .int_out_of_range_i(rng[0]), .underflow_trap_en_i(en[0]), .inexact_trap_en_i(en[1]),
        .int_overflow_trap_en_i(en[2]), .software_completion_qualifier_i(swc_i),
        .dest_valid_o(dest_valid_o), .dest_data_o(dest_data_o), .dest_unpredictable_o(unp),
        .trap_valid_o(trap_valid_o), .trap_kind_o(trap_kind_o),
        .software_completion_qualifier_o(swc_o), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    issue_unit_model model (.clock_i(clock_i), .reset_i(reset_i), .trap_valid_i(trap_valid_o),
        .swc_i(swc_o), .swc_summary_o(summ));
    // clock, 4 ns period
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    // compare and count
    task chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, then one idle edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_i);
    endtask
    // one op; f holds the flags it must record
    task op(input logic [2:0] c, ie, a, b, input logic [3:0] r, input logic [2:0] e,
            input logic s, input logic [5:0] f);
        op_valid_i <= 1'b1;
        op_class_i <= c;
        ieee_i <= ie[0];
        src_a_class_i <= a;
        src_b_class_i <= b;
        rng <= r;
        en <= e;
        swc_i <= s;
        @(posedge clock_i);
        op_valid_i <= 1'b0;
        #1;
        k = f & {e, 3'h7};
        if (c == 3'h4) k[4] = 1'b0;
        chk(dest_valid_o, 1'h1);
        chk(trap_valid_o, |k);
        chk(trap_kind_o, k);
        chk(unp, |f[2:0]);
        chk(swc_o, s);
        if (f[2:0] == 3'h0) chk(dest_data_o, r[2] ? 64'h0 : (r[0] ? TL : RR));
        ntrap += |k;
        acc |= f;
        @(posedge clock_i);
        apb(1'h0, 12'h004, 32'h0);
        chk(rd[5:0], f);
    endtask
    // closing report
    task conclude;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clock_i) begin
        cyc++;
        if (cyc > 2000) begin
            err_total++;
            conclude();
        end
    end
    // main sequence
    initial begin
        {reset_i, op_valid_i, ieee_i, swc_i, psel, penable, pwrite} = 7'h40;
        {op_class_i, src_a_class_i, src_b_class_i, en, rng, paddr, pwdata} = '0;
        acc = 6'h0;
        repeat (16) @(posedge clock_i);
        reset_i <= 1'b0;
        op(3'h0, 3'h1, 3'h1, 3'h1, 4'h2, 3'h0, 1'h1, 6'h10);
        chk(summ, 1'h0);
        op(3'h0, 3'h1, 3'h4, 3'h1, 4'h8, 3'h0, 1'h1, 6'h01);
        chk(summ, 1'h1);
        for (int i = 2; i < 7; i++) op(3'h0, i < 5, i, 3'h1, 4'h0, 3'h0, 1'h0, 6'h01);
        op(3'h2, 3'h1, 3'h4, 3'h4, 4'h0, 3'h0, 1'h0, 6'h00);
        op(3'h1, 3'h1, 3'h0, 3'h0, 4'h0, 3'h0, 1'h0, 6'h01);
        op(3'h1, 3'h1, 3'h1, 3'h0, 4'h8, 3'h0, 1'h0, 6'h02);
        op(3'h1, 3'h0, 3'h1, 3'h0, 4'h0, 3'h0, 1'h0, 6'h02);
        op(3'h1, 3'h1, 3'h1, 3'h1, 4'h0, 3'h0, 1'h0, 6'h00);
        op(3'h0, 3'h1, 3'h1, 3'h1, 4'h8, 3'h3, 1'h0, 6'h14);
        op(3'h0, 3'h1, 3'h1, 3'h1, 4'h6, 3'h0, 1'h0, 6'h18);
        op(3'h0, 3'h1, 3'h1, 3'h1, 4'h4, 3'h1, 1'h0, 6'h08);
        op(3'h0, 3'h1, 3'h1, 3'h1, 4'h4, 3'h3, 1'h0, 6'h18);
        op(3'h0, 3'h1, 3'h1, 3'h1, 4'h2, 3'h3, 1'h0, 6'h10);
        op(3'h3, 3'h1, 3'h1, 3'h0, 4'h1, 3'h4, 1'h0, 6'h20);
        op(3'h3, 3'h0, 3'h1, 3'h0, 4'h1, 3'h0, 1'h0, 6'h20);
        op(3'h4, 3'h1, 3'h1, 3'h0, 4'h1, 3'h6, 1'h0, 6'h30);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd[5:0], acc);
        apb(1'h1, 12'h000, 32'h3f);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 12'h008, 32'h0);
        chk(rd[15:0], ntrap[15:0]);
        apb(1'h0, 12'h00c, 32'h0);
        chk({se, rd}, {1'b1, 32'h0});
        conclude();
    end
endmodule // testbench
